/* rtl/plsr_port_regs.sv */
// Notes on behaviour
// - Capability bit 19 reads 1 downstream, zero upstream.
// - Capability bit 20 reads 1 downstream, zero upstream.
// - Capability bits 31:24 give the port number from PORT_NUM.
// - Station strap value selects x16, x8x8, or x8x4x4 lane split.
// - ASPM field 1:0 gates L0s and L1 entry.
// - Receiver may always enter L0s regardless of ASPM.
// - Completion boundary bit 3 is read-only zero.
// - Downstream bit 4 holds link in Disabled state until cleared.
// - Downstream bit 5 write starts retraining; reads zero.
// - Bit 6 is read-write common reference clock indicator.
// - Extended sync selects 4096 FTS and 1024 TS1.
// - Clock PM bits 8 and 18 read zero; bits 15:9 zero.
// - Link speed field reads 0001b.
// - Negotiated width is zero when down or unsupported, else one-hot up to x16.
// - Downstream bit 27 shows training requested or in progress.
// - Status bit 28 is hardware-initialized slot clock choice.
// - Downstream bit 29 shows DL active, link up, flow control done.
// - Slot capability zero upstream; presence fields only on hot-plug ports.
// - Hot-plug presence bits 0 to 4 default 1, loader writable.
// - Surprise bit 5 defaults 0, hot-plug bit 6 defaults 1.
// - Power limit value defaults 19h, scale defaults 00b.
// - Send power limit message on loader write or DL up.
// - DL active change raises hot-plug interrupt or PME when enabled.
`timescale 1ns/100ps
`default_nettype none
module plsr_port_regs
  import plsr_pkg::*;
#(
  parameter int unsigned PORT_NUM = 1  // Port number within the switch.
)
(
  input  wire logic           mclk,                       // Clock.
  input  wire logic           rst,                        // Synchronous reset.
  input  wire plsr_cfg_req_t  cfg_req,                    // Config access.
  output logic [31:0]         cfg_rdata,                  // Read data.
  input  wire logic [2:0]     station_a_lane_split_strap, // Station 0 strap.
  input  wire logic [2:0]     station_b_lane_split_strap, // Station 1 strap.
  input  wire logic [2:0]     station_c_lane_split_strap, // Station 2 strap.
  input  wire plsr_link_sts_t link_sts,                   // Link layer status.
  input  wire logic           rx_l0s_req,                 // Receiver wants L0s.
  input  wire logic           spl_ack,                    // Power limit msg taken.
  input  wire logic           slot_ev_en,                 // Slot ctl bit 12 state.
  input  wire logic           pm_d3hot,                   // Port in D3hot.
  output logic                l0s_tx_allow,               // Tx L0s entry allowed.
  output logic                l1_allow,                   // L1 entry allowed.
  output logic                rx_l0s_allow,               // Rx L0s entry allowed.
  output logic                link_disable,               // Hold link Disabled.
  output logic                retrain_pulse,              // Start retraining.
  output logic [12:0]         fts_count,                  // FTS sets on L0s exit.
  output logic [12:0]         ts1_count,                  // TS1 sets in Recovery.
  output logic [5:0]          max_width,                  // Lane split width.
  output logic                spl_send,                   // Send power limit msg.
  output logic                hp_irq,                     // Hot-plug interrupt.
  output logic                pme_req                     // PME message request.
);
  localparam bit IS_UP = (PORT_NUM == 0);
  localparam bit IS_HP = (PORT_NUM == 1) || (PORT_NUM == 8) || (PORT_NUM == 9);
  localparam int unsigned STN_BASE = (PORT_NUM >= 12) ? 12 : (PORT_NUM >= 8) ? 8 : 0;
  localparam int unsigned STN_IDX  = PORT_NUM - STN_BASE;

  // Only the nine switch ports exist; any other number has no station to take its strap from.
  if (!(PORT_NUM inside {0, 1, 2, 8, 9, 10, 12, 13, 14})) begin : g_bad_port
    $error("plsr_port_regs: unsupported port number");
  end

  // Straps pass two flops; the first is read only by the second.
  logic [2:0] strap_s1_ff;
  logic [2:0] strap_s2_ff;
  logic [2:0] strap_cfg_ff;
  logic       strap_cap_ff;
  wire  [2:0] strap_raw = (STN_BASE == 12) ? station_c_lane_split_strap :
                          (STN_BASE == 8)  ? station_b_lane_split_strap :
                                             station_a_lane_split_strap;

  // Writable and hardware-initialized state.
  logic [1:0] aspm_ff;
  logic       ldis_ff;
  logic       cclk_ff;
  logic       esync_ff;
  logic       sclk_ff;
  logic [4:0] pres_ff;
  logic       hpsur_ff;
  logic       hpcap_ff;
  logic [7:0] plv_ff;
  logic [1:0] pls_ff;
  logic       retrain_ff;
  logic       train_req_ff;
  logic       dlact_ff;
  logic [5:0] width_ff;
  logic       hp_irq_ff;
  logic       pme_ff;
  logic [31:0] rdata_ff;

  wire wr_lstct = cfg_req.wr && cfg_req.addr == PLSR_OFS_LINK_STCT;
  wire wr_scap  = cfg_req.wr && cfg_req.addr == PLSR_OFS_SLOT_CAP;
  wire ld_lstct = wr_lstct && cfg_req.loader;
  wire ld_scap  = wr_scap && cfg_req.loader && !IS_UP;
  wire dlact_now = !IS_UP && link_sts.dl_active && link_sts.link_up && link_sts.fc_init_done;
  wire dl_up_ev  = dlact_now && !dlact_ff;
  wire dl_chg_ev = dlact_now != dlact_ff;
  wire spl_trig  = ld_scap || dl_up_ev;
  wire retrain_wr = wr_lstct && !IS_UP && cfg_req.wdata[PLSR_LCTL_RETRAIN_BIT];

  // Width per lane split and position within the station.
  wire [5:0] split_width =
    (strap_cfg_ff == PLSR_CFG_X16)  ? ((STN_IDX == 0) ? PLSR_WIDTH_X16 : PLSR_WIDTH_DOWN) :
    (strap_cfg_ff == PLSR_CFG_X8X8) ? ((STN_IDX == 2) ? PLSR_WIDTH_DOWN : 6'h08) :
                                      ((STN_IDX == 0) ? 6'h08 : 6'h04);

  // Only zero or a single supported one-hot width is reported.
  wire width_ok = link_sts.link_up && link_sts.neg_width inside {6'h01, 6'h02, 6'h04, 6'h08, 6'h10};

  wire [31:0] lcap_val = {8'(PORT_NUM), 3'h0, !IS_UP, !IS_UP, 1'b0, PLSR_LCAP_L1_LAT,
                          PLSR_LCAP_L0S_LAT, PLSR_LCAP_ASPM_SUP, max_width, PLSR_LCAP_SPEED};
  wire [31:0] lstct_val = {2'h0, dlact_ff, sclk_ff, train_req_ff, 1'b0, width_ff, PLSR_LSTS_SPEED,
                           7'h00, 1'b0, esync_ff, cclk_ff, 1'b0, ldis_ff, 1'b0, 1'b0, aspm_ff};
  wire [31:0] scap_val = IS_UP ? 32'h0000_0000 :
                         {15'h0000, pls_ff, plv_ff,
                          IS_HP ? {hpcap_ff, hpsur_ff, pres_ff} : 7'h00};

  always_ff @(posedge mclk) begin
    strap_s1_ff <= strap_raw;
    strap_s2_ff <= strap_s1_ff;
  end

  // The strap is sampled once, on the first cycle after reset release.
  always_ff @(posedge mclk) begin
    if (rst) begin
      strap_cfg_ff <= 3'h0;
      strap_cap_ff <= 1'b0;
    end else if (!strap_cap_ff) begin
      strap_cfg_ff <= strap_s2_ff;
      strap_cap_ff <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) max_width <= PLSR_WIDTH_DOWN;
    else     max_width <= split_width;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      aspm_ff  <= 2'h0;
      ldis_ff  <= 1'b0;
      cclk_ff  <= 1'b0;
      esync_ff <= 1'b0;
      sclk_ff  <= 1'b0;
    end else if (wr_lstct) begin
      aspm_ff  <= cfg_req.wdata[1:0];
      ldis_ff  <= !IS_UP && cfg_req.wdata[PLSR_LCTL_DIS_BIT];
      cclk_ff  <= cfg_req.wdata[PLSR_LCTL_CCLK_BIT];
      esync_ff <= cfg_req.wdata[PLSR_LCTL_ESYNC_BIT];
      if (ld_lstct) sclk_ff <= cfg_req.wdata[PLSR_LSTS_SCLK_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pres_ff  <= PLSR_SCAP_PRES_DEF;
      hpsur_ff <= 1'b0;
      hpcap_ff <= 1'b1;
      plv_ff   <= PLSR_SCAP_PLV_DEF;
      pls_ff   <= PLSR_SCAP_PLS_DEF;
    end else if (ld_scap) begin
      pres_ff  <= cfg_req.wdata[4:0];
      hpsur_ff <= cfg_req.wdata[PLSR_SCAP_HPSUR_BIT];
      hpcap_ff <= cfg_req.wdata[PLSR_SCAP_HPCAP_BIT];
      plv_ff   <= cfg_req.wdata[PLSR_SCAP_PLV_LSB +: 8];
      pls_ff   <= cfg_req.wdata[PLSR_SCAP_PLS_LSB +: 2];
    end
  end

  // Training request is set for one cycle by the retrain write and holds on only if the link trains, until link up.
  always_ff @(posedge mclk) begin
    if (rst) begin
      retrain_ff   <= 1'b0;
      train_req_ff <= 1'b0;
      dlact_ff     <= 1'b0;
      width_ff     <= PLSR_WIDTH_DOWN;
    end else begin
      retrain_ff   <= retrain_wr;
      train_req_ff <= !IS_UP && (retrain_wr || link_sts.training ||
                                 (train_req_ff && !retrain_ff && !link_sts.link_up));
      dlact_ff     <= dlact_now;
      width_ff     <= width_ok ? link_sts.neg_width : PLSR_WIDTH_DOWN;
    end
  end

  // DL active changes notify by interrupt in D0 or PME in D3hot.
  always_ff @(posedge mclk) begin
    if (rst) begin
      hp_irq_ff <= 1'b0;
      pme_ff    <= 1'b0;
    end else begin
      hp_irq_ff <= !IS_UP && dl_chg_ev && slot_ev_en && !pm_d3hot;
      pme_ff    <= !IS_UP && dl_chg_ev && slot_ev_en && pm_d3hot;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_ff      <= 32'h0000_0000;
      l0s_tx_allow  <= 1'b0;
      l1_allow      <= 1'b0;
      rx_l0s_allow  <= 1'b0;
      fts_count     <= 13'h0000;
      ts1_count     <= 13'h0000;
    end else begin
      rdata_ff      <= !cfg_req.rd ? 32'h0000_0000 :
                       (cfg_req.addr == PLSR_OFS_LINK_CAP)  ? lcap_val :
                       (cfg_req.addr == PLSR_OFS_LINK_STCT) ? lstct_val :
                       (cfg_req.addr == PLSR_OFS_SLOT_CAP)  ? scap_val : 32'h0000_0000;
      l0s_tx_allow  <= aspm_ff[0];
      l1_allow      <= aspm_ff[1];
      rx_l0s_allow  <= rx_l0s_req;
      fts_count     <= esync_ff ? PLSR_FTS_EXT : 13'h0000;
      ts1_count     <= esync_ff ? PLSR_TS1_EXT : 13'h0000;
    end
  end

  plsr_spl_msg u_spl (
    .mclk (mclk),
    .rst  (rst),
    .trig (spl_trig),
    .ack  (spl_ack),
    .send (spl_send)
  );

  assign cfg_rdata     = rdata_ff;
  assign link_disable  = ldis_ff;
  assign retrain_pulse = retrain_ff;
  assign hp_irq        = hp_irq_ff;
  assign pme_req       = pme_ff;

  // Steps of a retrain request on the pulse output; a second write at once stretches it.
  sequence retrain_once_s;
    retrain_pulse ##1 (retrain_pulse == $past(retrain_wr));
  endsequence

  retrain_pulse_a: assert property (@(posedge mclk) disable iff (rst)
    retrain_wr |=> retrain_once_s) else $error("retrain pulse wrong");
  train_req_a: assert property (@(posedge mclk) disable iff (rst)
    retrain_wr |=> train_req_ff) else $error("training request not shown");
  retrain_rd_a: assert property (@(posedge mclk) disable iff (rst)
    cfg_req.rd && cfg_req.addr == PLSR_OFS_LINK_STCT |=> !cfg_rdata[PLSR_LCTL_RETRAIN_BIT] &&
    !cfg_rdata[PLSR_LCTL_RCB_BIT] && cfg_rdata[15:8] == 8'h00) else $error("link control reads bad");
  speed_rd_a: assert property (@(posedge mclk) disable iff (rst)
    cfg_req.rd && cfg_req.addr == PLSR_OFS_LINK_STCT |=>
    cfg_rdata[PLSR_LSTS_SPEED_LSB +: 4] == PLSR_LSTS_SPEED) else $error("link speed reads bad");
  aspm_wr_a: assert property (@(posedge mclk) disable iff (rst)
    wr_lstct |=> aspm_ff == $past(cfg_req.wdata[1:0])) else $error("aspm write lost");
  aspm_gate_a: assert property (@(posedge mclk) disable iff (rst)
    $stable(aspm_ff) |-> l0s_tx_allow == aspm_ff[0] && l1_allow == aspm_ff[1]) else $error("aspm gate");
  rx_l0s_a: assert property (@(posedge mclk) disable iff (rst)
    rx_l0s_req |=> rx_l0s_allow) else $error("receiver L0s blocked");
  cclk_wr_a: assert property (@(posedge mclk) disable iff (rst)
    wr_lstct |=> cclk_ff == $past(cfg_req.wdata[PLSR_LCTL_CCLK_BIT])) else $error("common clock write lost");
  lcap_bits_a: assert property (@(posedge mclk) disable iff (rst)
    cfg_req.rd && cfg_req.addr == PLSR_OFS_LINK_CAP |=> cfg_rdata[PLSR_LCAP_SDERR_BIT] == !IS_UP &&
    cfg_rdata[PLSR_LCAP_DLLAR_BIT] == !IS_UP && !cfg_rdata[PLSR_LCAP_CPM_BIT] &&
    cfg_rdata[31:PLSR_LCAP_PNUM_LSB] == 8'(PORT_NUM)) else $error("link capability bits");
  scap_rsv_a: assert property (@(posedge mclk) disable iff (rst)
    cfg_req.rd && cfg_req.addr == PLSR_OFS_SLOT_CAP |=> cfg_rdata[31:17] == 15'h0000 &&
    (IS_HP || cfg_rdata[6:0] == 7'h00) && (!IS_UP || cfg_rdata == 32'h0000_0000))
    else $error("slot capability reserved");
  width_a: assert property (@(posedge mclk) disable iff (rst)
    !link_sts.link_up |=> width_ff == PLSR_WIDTH_DOWN) else $error("width not down");
  width_copy_a: assert property (@(posedge mclk) disable iff (rst)
    width_ok |=> width_ff == $past(link_sts.neg_width)) else $error("width not copied");
  width_onehot_a: assert property (@(posedge mclk) disable iff (rst)
    $onehot0(max_width)) else $error("lane split width not one-hot");
  dlact_a: assert property (@(posedge mclk) disable iff (rst)
    dlact_ff |-> !IS_UP && $past(link_sts.fc_init_done) && $past(link_sts.dl_active)) else $error("dl active");
  hp_irq_a: assert property (@(posedge mclk) disable iff (rst)
    dl_chg_ev && slot_ev_en && !pm_d3hot && !IS_UP |=> hp_irq && !pme_req) else $error("no hot-plug irq");
  pme_req_a: assert property (@(posedge mclk) disable iff (rst)
    dl_chg_ev && slot_ev_en && pm_d3hot && !IS_UP |=> pme_req && !hp_irq) else $error("no PME request");
  no_event_a: assert property (@(posedge mclk) disable iff (rst)
    !(dl_chg_ev && slot_ev_en) |=> !hp_irq && !pme_req) else $error("spurious notification");
  ldis_a: assert property (@(posedge mclk) disable iff (rst)
    wr_lstct && !IS_UP && cfg_req.wdata[PLSR_LCTL_DIS_BIT] |=> link_disable) else $error("disable lost");
  ldis_clr_a: assert property (@(posedge mclk) disable iff (rst)
    wr_lstct && !cfg_req.wdata[PLSR_LCTL_DIS_BIT] |=> !link_disable) else $error("disable not cleared");
  esync_a: assert property (@(posedge mclk) disable iff (rst)
    esync_ff && $stable(esync_ff) |=> fts_count == PLSR_FTS_EXT && ts1_count == PLSR_TS1_EXT) else $error("esync");
  fts_off_a: assert property (@(posedge mclk) disable iff (rst)
    !esync_ff |=> fts_count == 13'h0000 && ts1_count == 13'h0000) else $error("normal sync counts");
  // Link-side writes must never reach the hardware-initialized slot and clock fields.
  hwinit_a: assert property (@(posedge mclk) disable iff (rst)
    wr_scap && !cfg_req.loader |=> $stable(plv_ff) && $stable(pres_ff)) else $error("link write hwinit");
  scap_hold_a: assert property (@(posedge mclk) disable iff (rst)
    !ld_scap |=> $stable(pls_ff) && $stable(hpsur_ff) && $stable(hpcap_ff)) else $error("slot fields moved");
  sclk_hold_a: assert property (@(posedge mclk) disable iff (rst)
    !ld_lstct |=> $stable(sclk_ff)) else $error("slot clock bit moved");
endmodule : plsr_port_regs
`default_nettype wire

/* rtl/plsr_pkg.sv */
package plsr_pkg;

  localparam logic [11:0] PLSR_OFS_LINK_CAP  = 12'h074;
  localparam logic [11:0] PLSR_OFS_LINK_STCT = 12'h078;
  localparam logic [11:0] PLSR_OFS_SLOT_CAP  = 12'h07C;

  // Link capability field positions.
  localparam int PLSR_LCAP_SDERR_BIT  = 19;
  localparam int PLSR_LCAP_DLLAR_BIT  = 20;
  localparam int PLSR_LCAP_PNUM_LSB   = 24;
  localparam int PLSR_LCAP_CPM_BIT    = 18;
  localparam int PLSR_LCAP_WIDTH_LSB  = 4;
  localparam logic [3:0]  PLSR_LCAP_SPEED    = 4'h1;
  localparam logic [1:0]  PLSR_LCAP_ASPM_SUP = 2'h3;
  localparam logic [2:0]  PLSR_LCAP_L0S_LAT  = 3'h5;
  localparam logic [2:0]  PLSR_LCAP_L1_LAT   = 3'h5;

  // Link control / status field positions.
  localparam int PLSR_LCTL_RCB_BIT     = 3;
  localparam int PLSR_LCTL_DIS_BIT     = 4;
  localparam int PLSR_LCTL_RETRAIN_BIT = 5;
  localparam int PLSR_LCTL_CCLK_BIT    = 6;
  localparam int PLSR_LCTL_ESYNC_BIT   = 7;
  localparam int PLSR_LSTS_SPEED_LSB   = 16;
  localparam int PLSR_LSTS_WIDTH_LSB   = 20;
  localparam int PLSR_LSTS_TRAIN_BIT   = 27;
  localparam int PLSR_LSTS_SCLK_BIT    = 28;
  localparam int PLSR_LSTS_DLACT_BIT   = 29;
  localparam logic [3:0]  PLSR_LSTS_SPEED    = 4'h1;
  localparam logic [5:0]  PLSR_WIDTH_DOWN    = 6'h00;
  localparam logic [5:0]  PLSR_WIDTH_X16     = 6'h10;

  // Slot capability field positions and defaults.
  localparam int PLSR_SCAP_HPSUR_BIT = 5;
  localparam int PLSR_SCAP_HPCAP_BIT = 6;
  localparam int PLSR_SCAP_PLV_LSB   = 7;
  localparam int PLSR_SCAP_PLS_LSB   = 15;
  localparam logic [4:0] PLSR_SCAP_PRES_DEF = 5'h1F;
  localparam logic [7:0] PLSR_SCAP_PLV_DEF  = 8'h19;
  localparam logic [1:0] PLSR_SCAP_PLS_DEF  = 2'h0;

  localparam logic [1:0] PLSR_ASPM_L0S = 2'h1;
  localparam logic [1:0] PLSR_ASPM_L1  = 2'h2;

  localparam logic [2:0] PLSR_CFG_X16  = 3'h1;
  localparam logic [2:0] PLSR_CFG_X8X8 = 3'h2;

  // Extended sync ordered-set counts.
  localparam logic [12:0] PLSR_FTS_EXT  = 13'h1000;
  localparam logic [12:0] PLSR_TS1_EXT  = 13'h0400;

  typedef enum logic [1:0] {
    PLSR_ST_IDLE = 2'b00,
    PLSR_ST_WAIT = 2'b01,
    PLSR_ST_SEND = 2'b11
  } plsr_spl_st_t;

  // Config access from the link or from the serial loader.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        loader;
    logic [11:0] addr;
    logic [31:0] wdata;
  } plsr_cfg_req_t;

  // Link-layer status from the physical and data link layers.
  typedef struct packed {
    logic       link_up;
    logic       dl_active;
    logic       fc_init_done;
    logic       training;
    logic [5:0] neg_width;
  } plsr_link_sts_t;

endpackage : plsr_pkg

/* rtl/plsr_spl_msg.sv */
`timescale 1ns/100ps
`default_nettype none
module plsr_spl_msg
  import plsr_pkg::*;
(
  input  wire logic       mclk,      // Clock.
  input  wire logic       rst,       // Synchronous reset.
  input  wire logic       trig,      // Request a message.
  input  wire logic       ack,       // Message accepted by link.
  output logic            send       // Message request level.
);
  plsr_spl_st_t st_ff;
  plsr_spl_st_t nxt_st;
  logic         send_ff;

  // A trigger during a pending send is folded into it since the message carries live values; one in the ack cycle starts another.
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      PLSR_ST_IDLE: if (trig) nxt_st = PLSR_ST_WAIT;
      PLSR_ST_WAIT: nxt_st = PLSR_ST_SEND;
      PLSR_ST_SEND: if (ack) nxt_st = trig ? PLSR_ST_WAIT : PLSR_ST_IDLE;
      default:      nxt_st = PLSR_ST_IDLE;
    endcase
  end

  // The request level gets its own flop so the port sees no decode glitch between states.
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_ff   <= PLSR_ST_IDLE;
      send_ff <= 1'b0;
    end else begin
      st_ff   <= nxt_st;
      send_ff <= (nxt_st == PLSR_ST_SEND);
    end
  end

  assign send = send_ff;

  spl_wait_a: assert property (@(posedge mclk) disable iff (rst)
    trig && st_ff == PLSR_ST_IDLE |-> ##2 send) else $error("power limit message not raised");
endmodule : plsr_spl_msg
`default_nettype wire

/* tb/plsr_partner.sv */
`timescale 1ns/100ps
`default_nettype none
module plsr_partner
  import plsr_pkg::*;
(
  input  wire logic          mclk,         // Clock.
  input  wire logic          rst,          // Synchronous reset.
  input  wire logic          up,           // Partner present and powered.
  input  wire logic          slow,         // Delay message acceptance.
  input  wire logic          link_disable, // Link held in Disabled.
  input  wire logic          spl_send,     // Power limit message pending.
  output var plsr_link_sts_t link_sts,     // Link layer status.
  output var logic           spl_ack       // Message accepted.
);
  logic [2:0] wait_ff;
  wire        alive = up & ~link_disable;
  // Changes land on the falling edge, so the block always samples settled levels.
  always_ff @(negedge mclk) begin
    if (rst) begin
      link_sts <= '0;
      spl_ack  <= 1'b0;
      wait_ff  <= 3'h0;
    end else begin
      link_sts.link_up      <= alive;
      link_sts.dl_active    <= link_sts.link_up & alive;
      link_sts.fc_init_done <= link_sts.link_up & alive;
      link_sts.training     <= alive & ~link_sts.link_up;
      link_sts.neg_width    <= alive ? 6'h04 : PLSR_WIDTH_DOWN;
      wait_ff               <= (spl_send & ~spl_ack) ? wait_ff + 3'h1 : 3'h0;
      spl_ack               <= spl_send & ~spl_ack & (~slow | (wait_ff == 3'h4));
    end
  end
endmodule : plsr_partner
`default_nettype wire

/* tb/pcie_port_link_slot_regs_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module pcie_port_link_slot_regs_bench;
  import plsr_pkg::*;
  localparam logic [31:0] SCAP_DEF = {15'h0, PLSR_SCAP_PLS_DEF, PLSR_SCAP_PLV_DEF, 1'b1, 1'b0, PLSR_SCAP_PRES_DEF};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  plsr_cfg_req_t  cfg_req;
  plsr_link_sts_t link_sts;
  logic [31:0] cfg_rdata, d, nv, exp_q[$];
  logic [12:0] fts_count, ts1_count;
  logic [5:0]  max_width;
  logic [7:0]  ctl;
  logic [2:0]  strap;
  logic rx_l0s_req, spl_ack, slot_ev_en, pm_d3hot, up, slow, sc, rd_q, spl_q;
  logic l0s_tx_allow, l1_allow, rx_l0s_allow, link_disable, retrain_pulse, spl_send, hp_irq, pme_req;
  int mismatches, compares, n_irq, n_pme, n_spl, n_rt;
  int seed = 97051;

  plsr_port_regs #(.PORT_NUM(1)) DUT (.mclk(mclk), .rst(rst), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
    .station_a_lane_split_strap(strap), .station_b_lane_split_strap(strap), .station_c_lane_split_strap(strap),
    .link_sts(link_sts), .rx_l0s_req(rx_l0s_req), .spl_ack(spl_ack), .slot_ev_en(slot_ev_en),
    .pm_d3hot(pm_d3hot), .l0s_tx_allow(l0s_tx_allow), .l1_allow(l1_allow), .rx_l0s_allow(rx_l0s_allow),
    .link_disable(link_disable), .retrain_pulse(retrain_pulse), .fts_count(fts_count), .ts1_count(ts1_count),
    .max_width(max_width), .spl_send(spl_send), .hp_irq(hp_irq), .pme_req(pme_req));
  plsr_partner PEER (.mclk(mclk), .rst(rst), .up(up), .slow(slow), .link_disable(link_disable),
    .spl_send(spl_send), .link_sts(link_sts), .spl_ack(spl_ack));

  initial begin
    forever #5 mclk = ~mclk;
  end

  task automatic chk_rd(logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("Error cfg_rdata expected %h seen %h", e, g);
    end
  endtask : chk_rd

  task automatic chk_out(string n, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk_out

  task automatic cyc(int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  task automatic acc(logic w, logic r, logic l, logic [11:0] a, logic [31:0] wd);
    cfg_req = {w, r, l, a, wd};
    cyc(1);
  endtask : acc

  task automatic wr(logic l, logic [11:0] a, logic [31:0] wd);
    acc(1'b1, 1'b0, l, a, wd);
    acc(1'b0, 1'b0, 1'b0, 12'h000, 32'h0);
  endtask : wr

  // The expected word is queued first; the monitor pops it when the data appears.
  task automatic rd(logic [11:0] a, logic [31:0] e);
    exp_q.push_back(e);
    acc(1'b0, 1'b1, 1'b0, a, 32'h0);
    acc(1'b0, 1'b0, 1'b0, 12'h000, 32'h0);
  endtask : rd

  task automatic do_reset();
    rst = 1'b1;
    {n_irq, n_pme, n_spl, n_rt} = '0;
    spl_q = 1'b0;
    cyc(16);
    rst = 1'b0;
  endtask : do_reset

  function automatic logic [31:0] lsc(logic [7:0] c, logic [5:0] nw, logic tr, logic s, logic dla);
    return {2'b00, dla, s, tr, 1'b0, nw, PLSR_LSTS_SPEED, 8'h00, c};
  endfunction : lsc

  function automatic logic [5:0] wexp(logic [2:0] s);
    return (s == PLSR_CFG_X16) ? 6'h00 : (s == PLSR_CFG_X8X8) ? 6'h08 : 6'h04;
  endfunction : wexp

  task automatic conclude();
    $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  always @(posedge mclk) rd_q <= cfg_req.rd & ~rst;

  always @(negedge mclk) begin
    if (rd_q)
      chk_rd(exp_q.pop_front(), cfg_rdata);
    if (!rst) begin
      if (hp_irq === 1'b1) n_irq++;
      if (pme_req === 1'b1) n_pme++;
      if (retrain_pulse === 1'b1) n_rt++;
      if (spl_send === 1'b1 && spl_q !== 1'b1) n_spl++;
      spl_q = spl_send;
    end
  end

  initial begin
    #50000;
    mismatches++;
    conclude();
  end

  initial begin
    {cfg_req, strap, rx_l0s_req, slot_ev_en, pm_d3hot, up, slow, sc} = '0;
    cyc(1);
    for (int s = 0; s < 8; s++) begin
      strap = s[2:0];
      do_reset();
      cyc(8);
      chk_out("max_width", wexp(strap), max_width);
      rd(PLSR_OFS_LINK_CAP, {8'h01, 3'h0, 2'b11, 1'b0, PLSR_LCAP_L1_LAT, PLSR_LCAP_L0S_LAT,
         PLSR_LCAP_ASPM_SUP, wexp(strap), PLSR_LCAP_SPEED});
    end
    $display("Test straps done");
    slow = 1'b1;
    rd(PLSR_OFS_SLOT_CAP, SCAP_DEF);
    wr(1'b0, PLSR_OFS_SLOT_CAP, $random(seed));
    rd(PLSR_OFS_SLOT_CAP, SCAP_DEF);
    d = $random(seed);
    nv = {15'h0, d[16:0]};
    wr(1'b1, PLSR_OFS_SLOT_CAP, nv);
    cyc(1);
    chk_out("spl_send", 16'h1, spl_send);
    cyc(2);
    chk_out("spl_send", 16'h1, spl_send);
    cyc(8);
    chk_out("spl_send", 16'h0, spl_send);
    rd(PLSR_OFS_SLOT_CAP, nv);
    $display("Test slot capability done");
    slow = 1'b0;
    rx_l0s_req = 1'b1;
    wr(1'b0, PLSR_OFS_LINK_STCT, 32'h1000_0000);
    rd(PLSR_OFS_LINK_STCT, lsc(8'h00, 6'h00, 1'b0, 1'b0, 1'b0));
    wr(1'b1, PLSR_OFS_LINK_STCT, 32'h1000_0000);
    sc = 1'b1;
    for (int a = 0; a < 4; a++) begin
      d = $random(seed);
      ctl = {d[7:6], 4'h0, a[1:0]};
      acc(1'b1, 1'b0, 1'b0, PLSR_OFS_LINK_STCT, {16'hFFFF, 8'hFF, d[7:6], 4'b0011, a[1:0]});
      rd(PLSR_OFS_LINK_STCT, lsc(ctl, 6'h00, 1'b0, sc, 1'b0));
      chk_out("l0s_tx_allow", {15'h0, a[0]}, l0s_tx_allow);
      chk_out("l1_allow", {15'h0, a[1]}, l1_allow);
      chk_out("rx_l0s_allow", 16'h1, rx_l0s_allow);
      chk_out("fts_count", d[7] ? PLSR_FTS_EXT : 13'h0, fts_count);
      chk_out("ts1_count", d[7] ? PLSR_TS1_EXT : 13'h0, ts1_count);
    end
    acc(1'b1, 1'b0, 1'b0, PLSR_OFS_LINK_STCT, {24'h0, ctl | 8'h20});
    rd(PLSR_OFS_LINK_STCT, lsc(ctl, 6'h00, 1'b1, sc, 1'b0));
    chk_out("retrain_pulses", 16'h1, n_rt[15:0]);
    $display("Test link control done");
    slot_ev_en = 1'b1;
    up = 1'b1;
    cyc(10);
    rd(PLSR_OFS_LINK_STCT, lsc(ctl, 6'h04, 1'b0, sc, 1'b1));
    chk_out("hp_irq_count", 16'h1, n_irq[15:0]);
    pm_d3hot = 1'b1;
    wr(1'b0, PLSR_OFS_LINK_STCT, {24'h0, ctl | 8'h10});
    cyc(1);
    chk_out("link_disable", 16'h1, link_disable);
    cyc(10);
    rd(PLSR_OFS_LINK_STCT, lsc(ctl | 8'h10, 6'h00, 1'b0, sc, 1'b0));
    chk_out("pme_count", 16'h1, n_pme[15:0]);
    wr(1'b0, PLSR_OFS_LINK_STCT, {24'h0, ctl});
    cyc(10);
    chk_out("pme_count", 16'h2, n_pme[15:0]);
    slot_ev_en = 1'b0;
    up = 1'b0;
    cyc(10);
    up = 1'b1;
    cyc(10);
    chk_out("pme_count", 16'h2, n_pme[15:0]);
    chk_out("hp_irq_count", 16'h1, n_irq[15:0]);
    chk_out("spl_count", 16'h4, n_spl[15:0]);
    chk_out("pending_reads", 16'h0, exp_q.size());
    $display("Test link events done");
    conclude();
  end
endmodule : pcie_port_link_slot_regs_bench
`default_nettype wire
